// File: rtl/tpm_top.sv
// Purpose: timer with four pin modes, flag and interrupt pulses
// Assumes: bus inputs synchronous to clk_i; pin may be asynchronous
// Notes: read data arrives one cycle after the read strobe
`timescale 1ns/10ps
module tpm_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // peripheral bus
    input wire tpm_pkg::tpm_bus_req_t bus_req_i,
    output tpm_pkg::tpm_bus_rsp_t bus_rsp_o,
    // timer pin, split into three signals
    input wire logic timer_pin_i,
    output logic timer_pin_o,
    output logic timer_pin_oe_o,
    // interrupt pulses to processor and dma
    output logic timer_irq_cpu_o,
    output logic timer_irq_dma_o
);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    tpm_pkg::tpm_ctrl_t ctrl_q;
    tpm_pkg::tpm_ctrl_t ctrl_d;
    logic [31:0] prd_q;
    logic [31:0] prd_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic rvalid_q;
    logic div_q;
    logic flag_prev_q;
    logic pin_q;
    logic pin_oe_q;
    logic irq_q;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    logic sel_ctrl;
    logic sel_cnt;
    logic sel_prd;
    logic wr_ctrl;
    logic wr_cnt;
    logic wr_prd;

    assign sel_ctrl = (bus_req_i.addr == tpm_pkg::TPM_CTRL_ADDR);
    assign sel_cnt = (bus_req_i.addr == tpm_pkg::TPM_CNT_ADDR);
    assign sel_prd = (bus_req_i.addr == tpm_pkg::TPM_PRD_ADDR);
    assign wr_ctrl = bus_req_i.wr & sel_ctrl;
    assign wr_cnt = bus_req_i.wr & sel_cnt;
    assign wr_prd = bus_req_i.wr & sel_prd;

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    tpm_pkg::tpm_mode_t mode;
    logic run;
    logic restart;

    assign mode = ctrl_q.csrc ? (ctrl_q.pin_fn ? tpm_pkg::TPM_MODE_TOUT
                                               : tpm_pkg::TPM_MODE_GPIO)
                              : (ctrl_q.pin_fn ? tpm_pkg::TPM_MODE_EDGE_CNT
                                               : tpm_pkg::TPM_MODE_PIN_CNT);
    // release bit runs the timer, go with release restarts
    assign run = ctrl_q.hold_release;
    assign restart = ctrl_q.go & ctrl_q.hold_release;

    // ------------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------------
    logic pin_lvl;
    logic pin_rise;
    logic pin_fall;
    logic dout_lvl;
    logic dout_rise;

    tpm_sync_edge u_pin_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .din_i(timer_pin_i),
        .level_o(pin_lvl),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );

    tpm_sync_edge u_dout_edge (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .din_i(ctrl_q.dout),
        .level_o(dout_lvl),
        .rise_o(dout_rise),
        .fall_o()
    );

    // ------------------------------------------------------------------
    // timer clock selection
    // ------------------------------------------------------------------
    logic int_tick;
    logic pin_tick;
    logic tick;

    assign int_tick = div_q;
    // invert picks falling edges of the pin
    assign pin_tick = ctrl_q.invert ? pin_fall : pin_rise;

    always_comb
    begin
        tick = 1'b0;
        unique case (mode)
            tpm_pkg::TPM_MODE_GPIO: tick = int_tick;
            tpm_pkg::TPM_MODE_TOUT: tick = int_tick;
            // rises of the output value count when driving
            tpm_pkg::TPM_MODE_PIN_CNT: tick = ctrl_q.dir ? dout_rise : pin_tick;
            tpm_pkg::TPM_MODE_EDGE_CNT: tick = pin_tick;
        endcase
    end

    // ------------------------------------------------------------------
    // counter and flag
    // ------------------------------------------------------------------
    logic [31:0] cnt;
    logic flag;

    tpm_pulse_gen u_pulse (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .run_i(run),
        .restart_i(restart),
        .clock_mode_i(ctrl_q.cp),
        .tick_i(tick),
        .period_i(prd_q),
        .cnt_wr_i(wr_cnt),
        .cnt_wdata_i(bus_req_i.wdata),
        .cnt_o(cnt),
        .flag_o(flag)
    );

    // ------------------------------------------------------------------
    // pin drive and input value
    // ------------------------------------------------------------------
    logic pin_drive_en;
    logic pin_drive_val;
    logic din_val;

    always_comb
    begin
        pin_drive_en = 1'b0;
        pin_drive_val = ctrl_q.dout;
        din_val = pin_lvl;
        unique case (mode)
            tpm_pkg::TPM_MODE_GPIO:
            begin
                // direction picks input or output value
                pin_drive_en = ctrl_q.dir;
                din_val = ctrl_q.dir ? ctrl_q.dout : pin_lvl;
            end
            tpm_pkg::TPM_MODE_TOUT:
            begin
                // timer output drives pin, invert applied
                pin_drive_en = 1'b1;
                pin_drive_val = flag ^ ctrl_q.invert;
                din_val = pin_lvl;
            end
            tpm_pkg::TPM_MODE_PIN_CNT:
            begin
                pin_drive_en = ctrl_q.dir;
                din_val = ctrl_q.dir ? ctrl_q.dout : pin_lvl;
            end
            tpm_pkg::TPM_MODE_EDGE_CNT:
            begin
                pin_drive_en = 1'b0;
                din_val = pin_lvl;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // control register update
    // ------------------------------------------------------------------
    always_comb
    begin
        ctrl_d = ctrl_q;
        // go clears itself once the restart has happened
        if (restart)
            ctrl_d.go = 1'b0;
        // flag and input value are not writable
        if (wr_ctrl)
        begin
            ctrl_d.pin_fn = bus_req_i.wdata[tpm_pkg::TPM_BIT_PIN_FN];
            ctrl_d.dir = bus_req_i.wdata[tpm_pkg::TPM_BIT_DIR];
            ctrl_d.dout = bus_req_i.wdata[tpm_pkg::TPM_BIT_DOUT];
            ctrl_d.go = bus_req_i.wdata[tpm_pkg::TPM_BIT_GO];
            ctrl_d.hold_release = bus_req_i.wdata[tpm_pkg::TPM_BIT_HOLD_REL];
            ctrl_d.cp = bus_req_i.wdata[tpm_pkg::TPM_BIT_CP];
            ctrl_d.csrc = bus_req_i.wdata[tpm_pkg::TPM_BIT_CSRC];
            ctrl_d.invert = bus_req_i.wdata[tpm_pkg::TPM_BIT_INVERT];
        end
    end

    assign prd_d = wr_prd ? bus_req_i.wdata : prd_q;

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    logic [31:0] ctrl_word;

    always_comb
    begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[tpm_pkg::TPM_BIT_PIN_FN] = ctrl_q.pin_fn;
        ctrl_word[tpm_pkg::TPM_BIT_DIR] = ctrl_q.dir;
        ctrl_word[tpm_pkg::TPM_BIT_DOUT] = ctrl_q.dout;
        ctrl_word[tpm_pkg::TPM_BIT_DIN] = din_val;
        ctrl_word[tpm_pkg::TPM_BIT_GO] = ctrl_q.go;
        ctrl_word[tpm_pkg::TPM_BIT_HOLD_REL] = ctrl_q.hold_release;
        ctrl_word[tpm_pkg::TPM_BIT_CP] = ctrl_q.cp;
        ctrl_word[tpm_pkg::TPM_BIT_CSRC] = ctrl_q.csrc;
        ctrl_word[tpm_pkg::TPM_BIT_INVERT] = ctrl_q.invert;
        ctrl_word[tpm_pkg::TPM_BIT_FLAG] = flag;
    end

    // unmapped reads return zero rather than stale data
    assign rdata_d = sel_ctrl ? ctrl_word :
                     sel_cnt ? cnt :
                     sel_prd ? prd_q : 32'h0000_0000;

    // ------------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------------
    // reset leaves the timer halted
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            ctrl_q <= '0;
            prd_q <= tpm_pkg::TPM_PRD_RST;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            prd_q <= prd_d;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            rdata_q <= tpm_pkg::TPM_RDATA_RST;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= bus_req_i.rd;
            if (bus_req_i.rd)
                rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
            div_q <= 1'b0;
        else if (restart)
            div_q <= 1'b0;
        else if (run)
            div_q <= ~div_q;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            pin_q <= 1'b0;
            pin_oe_q <= 1'b0;
        end
        else
        begin
            pin_q <= pin_drive_val;
            pin_oe_q <= pin_drive_en;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            flag_prev_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            flag_prev_q <= flag;
            irq_q <= flag & ~flag_prev_q;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign bus_rsp_o.rvalid = rvalid_q;
    assign bus_rsp_o.rdata = rdata_q;
    assign timer_pin_o = pin_q;
    assign timer_pin_oe_o = pin_oe_q;
    // same pulse to both paths, enables live elsewhere
    assign timer_irq_cpu_o = irq_q;
    assign timer_irq_dma_o = irq_q;

endmodule : tpm_top

// File: inc/tpm_pkg.sv
// Purpose: constants and types for the timer with pin modes and interrupt
// Assumes: one core clock, synchronous active-low reset
// Notes: register map, control field positions, reset values, bus carriers
package tpm_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [23:0] TPM_CTRL_ADDR = 24'h808020;
    localparam logic [23:0] TPM_CNT_ADDR = 24'h808024;
    localparam logic [23:0] TPM_PRD_ADDR = 24'h808028;

    // ------------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------------
    localparam int TPM_BIT_PIN_FN = 0;
    localparam int TPM_BIT_DIR = 1;
    localparam int TPM_BIT_DOUT = 2;
    localparam int TPM_BIT_DIN = 3;
    localparam int TPM_BIT_GO = 6;
    localparam int TPM_BIT_HOLD_REL = 7;
    localparam int TPM_BIT_CP = 8;
    localparam int TPM_BIT_CSRC = 9;
    localparam int TPM_BIT_INVERT = 10;
    localparam int TPM_BIT_FLAG = 11;

    // ------------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------------
    localparam logic [31:0] TPM_CNT_RST = 32'h0000_0000;
    localparam logic [31:0] TPM_PRD_RST = 32'h0000_0000;
    localparam logic [31:0] TPM_RDATA_RST = 32'h0000_0000;
    localparam logic TPM_CTRL_BIT_RST = 1'b0;
    // internal timer clock is the core clock divided by this
    localparam int TPM_INT_DIV = 2;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TPM_MODE_GPIO,
        TPM_MODE_TOUT,
        TPM_MODE_PIN_CNT,
        TPM_MODE_EDGE_CNT
    } tpm_mode_t;

    typedef struct packed {
        logic invert;
        logic csrc;
        logic cp;
        logic hold_release;
        logic go;
        logic dout;
        logic dir;
        logic pin_fn;
    } tpm_ctrl_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [23:0] addr;
        logic [31:0] wdata;
    } tpm_bus_req_t;

    typedef struct packed {
        logic rvalid;
        logic [31:0] rdata;
    } tpm_bus_rsp_t;

endpackage : tpm_pkg

// File: rtl/tpm_sync_edge.sv
// Purpose: two-stage synchroniser with edge pulses
// Assumes: input may be asynchronous to clk_i
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
module tpm_sync_edge (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // sampled signal
    input wire logic din_i,
    // synchronised level and edges
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);

    logic meta_q;
    logic sync_q;
    logic prev_q;

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            meta_q <= din_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_o = sync_q;
    assign rise_o = sync_q & ~prev_q;
    assign fall_o = ~sync_q & prev_q;

endmodule : tpm_sync_edge

// File: rtl/tpm_pulse_gen.sv
// Purpose: period counter and timer flag generator
// Assumes: tick_i is a one-cycle count enable
// Notes: bus writes to the counter win over counting
`timescale 1ns/10ps
module tpm_pulse_gen (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // control
    input wire logic run_i,
    input wire logic restart_i,
    input wire logic clock_mode_i,
    input wire logic tick_i,
    input wire logic [31:0] period_i,
    // counter write
    input wire logic cnt_wr_i,
    input wire logic [31:0] cnt_wdata_i,
    // state
    output logic [31:0] cnt_o,
    output logic flag_o
);

    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic flag_q;
    logic flag_d;
    logic [31:0] cnt_inc;
    logic zero_case;
    logic hit;
    logic fire;
    logic stale_eq;

    assign cnt_inc = cnt_q + 32'h0000_0001;
    // period and counter both zero: flag sticks or toggles at core rate
    assign zero_case = (period_i == 32'h0000_0000) && (cnt_q == 32'h0000_0000);
    assign hit = (cnt_inc == period_i);
    assign stale_eq = (cnt_q == period_i) && !zero_case;
    assign fire = run_i && tick_i && hit && !zero_case;

    always_comb
    begin
        cnt_d = cnt_q;
        flag_d = flag_q;
        if (restart_i)
        begin
            cnt_d = tpm_pkg::TPM_CNT_RST;
            flag_d = 1'b0;
        end
        else if (run_i)
        begin
            if (stale_eq)
                cnt_d = tpm_pkg::TPM_CNT_RST;
            else if (tick_i && !zero_case)
                cnt_d = hit ? tpm_pkg::TPM_CNT_RST : cnt_inc;
            // pulse one core cycle, clock mode toggles
            if (clock_mode_i)
                flag_d = flag_q ^ (fire | zero_case);
            else
                flag_d = fire | zero_case;
        end
        if (cnt_wr_i)
            cnt_d = cnt_wdata_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            cnt_q <= tpm_pkg::TPM_CNT_RST;
            flag_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            flag_q <= flag_d;
        end
    end

    assign cnt_o = cnt_q;
    assign flag_o = flag_q;

endmodule : tpm_pulse_gen

// File: tb/tpm_top_assertions.sv
// Purpose: port checker for tpm_top
// Assumes: one clock, synchronous active-low reset
// Notes: bound to tpm_top after the module
`timescale 1ns/10ps
module tpm_assert (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // peripheral bus
    input wire tpm_pkg::tpm_bus_req_t bus_req_i,
    input wire tpm_pkg::tpm_bus_rsp_t bus_rsp_o,
    // pin and interrupts
    input wire logic timer_pin_i,
    input wire logic timer_pin_o,
    input wire logic timer_pin_oe_o,
    input wire logic timer_irq_cpu_o,
    input wire logic timer_irq_dma_o
);
    wire ctrl_wr = bus_req_i.wr && bus_req_i.addr == tpm_pkg::TPM_CTRL_ADDR;
    wire mapped = bus_req_i.addr == tpm_pkg::TPM_CTRL_ADDR
        || bus_req_i.addr == tpm_pkg::TPM_CNT_ADDR
        || bus_req_i.addr == tpm_pkg::TPM_PRD_ADDR;
    // pin is driven in timer-output mode, or when direction is output in gpio and pin-count modes
    wire oe_want = bus_req_i.wdata[tpm_pkg::TPM_BIT_PIN_FN]
        ? bus_req_i.wdata[tpm_pkg::TPM_BIT_CSRC] : bus_req_i.wdata[tpm_pkg::TPM_BIT_DIR];
    wire dout_mode = !bus_req_i.wdata[tpm_pkg::TPM_BIT_PIN_FN]
        && bus_req_i.wdata[tpm_pkg::TPM_BIT_DIR];

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    property p_irq_pair;
        timer_irq_cpu_o == timer_irq_dma_o;
    endproperty
    a_irq_pair: assert property (p_irq_pair)
        else $error("cpu and dma interrupts differ");

    property p_irq_pulse;
        timer_irq_cpu_o |=> !timer_irq_cpu_o;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("interrupt longer than one cycle");

    property p_rvalid;
        1'b1 |=> bus_rsp_o.rvalid == $past(bus_req_i.rd);
    endproperty
    a_rvalid: assert property (p_rvalid)
        else $error("read valid not one cycle after read");

    property p_unmapped;
        bus_req_i.rd && !mapped |=> bus_rsp_o.rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_rdata_hold;
        !bus_rsp_o.rvalid |-> $stable(bus_rsp_o.rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved without a read");

    property p_oe_mode;
        ctrl_wr |-> ##2 timer_pin_oe_o == $past(oe_want, 2);
    endproperty
    a_oe_mode: assert property (p_oe_mode)
        else $error("pin enable wrong for mode");

    property p_dout_pin;
        ctrl_wr && dout_mode |-> ##2
            timer_pin_o == $past(bus_req_i.wdata[tpm_pkg::TPM_BIT_DOUT], 2);
    endproperty
    a_dout_pin: assert property (p_dout_pin)
        else $error("pin not following output value");

    property p_hold_quiet;
        ctrl_wr && !bus_req_i.wdata[tpm_pkg::TPM_BIT_HOLD_REL] |-> ##3 !timer_irq_cpu_o [*4];
    endproperty
    a_hold_quiet: assert property (p_hold_quiet)
        else $error("interrupt while held");
endmodule : tpm_assert

bind tpm_top tpm_assert tpm_assert_i (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .bus_req_i(bus_req_i),
    .bus_rsp_o(bus_rsp_o),
    .timer_pin_i(timer_pin_i),
    .timer_pin_o(timer_pin_o),
    .timer_pin_oe_o(timer_pin_oe_o),
    .timer_irq_cpu_o(timer_irq_cpu_o),
    .timer_irq_dma_o(timer_irq_dma_o)
);

// File: tb/tpm_pin_model.sv
// Purpose: outside source or load on the timer pin
// Assumes: weak pull-up on the pin
// Notes: steps aside whenever the block drives the pin
`timescale 1ns/10ps
module tpm_pin_model (
    // bench control
    input wire logic drive_i,
    input wire logic level_i,
    // block side
    input wire logic pin_o_i,
    input wire logic pin_oe_i,
    // resolved wire
    output logic pin_w_o
);
    // released pin floats up, never to a stale value
    assign pin_w_o = pin_oe_i ? pin_o_i : (drive_i ? level_i : 1'b1);
endmodule : tpm_pin_model

// File: tb/tpm_bench.sv
// Purpose: self-checking bench for tpm_top
// Assumes: 100 MHz clock, reset low 6 cycles
// Notes: bus reads answer one cycle after the strobe
`timescale 1ns/10ps
module tpm_bench;
    localparam logic [23:0] A_CTL = tpm_pkg::TPM_CTRL_ADDR;
    localparam logic [23:0] A_CNT = tpm_pkg::TPM_CNT_ADDR;
    localparam logic [23:0] A_PRD = tpm_pkg::TPM_PRD_ADDR;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    tpm_pkg::tpm_bus_req_t req = '0;
    tpm_pkg::tpm_bus_rsp_t rsp;
    logic pin_o, pin_oe, irq_c, irq_d;
    logic drv = 1'b1;
    logic lvl = 1'b0;
    wire pin_w;
    int n_errors = 0;
    int checked = 0;
    int c;
    logic [31:0] x, y;
    logic [31:0] cfg [3] = '{32'h2c1, 32'h3c1, 32'h6c1};
    int gap [3] = '{6, 12, 6};
    int wid [3] = '{1, 6, 1};
    logic [31:0] mb [6] = '{32'h0, 32'h400, 32'h1, 32'h401, 32'h2, 32'h402};
    logic [31:0] ce [6] = '{32'h3, 32'h2, 32'h3, 32'h2, 32'h3, 32'h3};

    always #5 clk_i = ~clk_i;

    tpm_top tpm_top_i (.clk_i(clk_i), .rstn_i(rstn_i), .bus_req_i(req), .bus_rsp_o(rsp),
        .timer_pin_i(pin_w), .timer_pin_o(pin_o), .timer_pin_oe_o(pin_oe),
        .timer_irq_cpu_o(irq_c), .timer_irq_dma_o(irq_d));
    tpm_pin_model tpm_pin_model_i (.drive_i(drv), .level_i(lvl), .pin_o_i(pin_o),
        .pin_oe_i(pin_oe), .pin_w_o(pin_w));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic finish_test;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

    task automatic wr(input logic [23:0] a, input logic [31:0] d);
        @(posedge clk_i);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        req.wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [23:0] a, output logic [31:0] d);
        @(posedge clk_i);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk_i);
        req.rd <= 1'b0;
        #1;
        chk({31'h0, rsp.rvalid}, 32'h1, "read valid");
        d = rsp.rdata;
    endtask : rd

    task automatic rdchk(input logic [23:0] a, input logic [31:0] e, input string what);
        logic [31:0] d;
        rd(a, d);
        chk(d, e, what);
    endtask : rdchk

    // bounded wait, one cycle at least
    task automatic wait_irq(output int n);
        n = 0;
        do
        begin
            tick(1);
            n++;
        end while (irq_c !== 1'b1 && n < 200);
        if (n >= 200)
        begin
            n_errors++;
            $display("CHECK FAILED %0t no interrupt", $time);
            finish_test();
        end
    endtask : wait_irq

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge clk_i);
        rstn_i <= 1'b1;
        tick(1);
        rdchk(A_CTL, 32'h0, "ctrl reset");
        rdchk(A_CNT, 32'h0, "count reset");
        rdchk(A_PRD, 32'h0, "period reset");
        rdchk(24'h80802c, 32'h0, "unmapped");
        wr(A_CTL, 32'h0);
        wr(A_CTL, 32'h808);
        rdchk(A_CTL, 32'h0, "read-only bits");
        wr(A_CTL, 32'h206);
        tick(2);
        chk({30'h0, pin_oe, pin_w}, 32'h3, "gpio drive");
        rdchk(A_CTL, 32'h20e, "gpio readback");
        wr(A_CTL, 32'h204);
        tick(4);
        chk({31'h0, pin_oe}, 32'h0, "gpio input");
        rdchk(A_CTL, 32'h204, "input low");
        @(posedge clk_i);
        // released pin is pulled high
        drv <= 1'b0;
        tick(4);
        rdchk(A_CTL, 32'h20c, "input high");
        wr(A_PRD, 32'h3);
        for (int k = 0; k < 3; k++)
        begin
            wr(A_CTL, 32'h0);
            wr(A_CTL, cfg[k] & 32'hf3f);
            wr(A_CTL, cfg[k]);
            wait_irq(c);
            wait_irq(c);
            chk(32'(c), 32'(gap[k]), "irq spacing");
            chk({31'h0, irq_d}, 32'h1, "dma irq");
            chk({31'h0, pin_w}, {31'h0, ~cfg[k][10]}, "pin at irq");
            tick(wid[k] - 1);
            chk({31'h0, pin_w}, {31'h0, ~cfg[k][10]}, "pin width");
            tick(1);
            chk({31'h0, pin_w}, {31'h0, cfg[k][10]}, "pin back");
        end
        wr(A_CTL, 32'h200);
        rd(A_CNT, x);
        tick(5);
        rd(A_CNT, y);
        chk(y, x, "frozen count");
        chk({31'h0, x < 32'h3}, 32'h1, "count below period");
        wr(A_CTL, 32'h2c1);
        tick(9);
        @(posedge clk_i);
        rstn_i <= 1'b0;
        // pin held low so no false edge follows reset
        drv <= 1'b1;
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        tick(1);
        rdchk(A_CTL, 32'h0, "ctrl after reset");
        rdchk(A_CNT, 32'h0, "count after reset");
        wr(A_PRD, 32'h3e8);
        for (int k = 0; k < 6; k++)
        begin
            wr(A_CTL, mb[k]);
            @(posedge clk_i);
            lvl <= 1'b0;
            tick(6);
            wr(A_CTL, mb[k] | 32'hc0);
            tick(4);
            for (int t = 0; t < 5; t++)
            begin
                if (k < 4)
                begin
                    @(posedge clk_i);
                    lvl <= ~lvl;
                end
                else
                    wr(A_CTL, mb[k] | 32'h80 | ((t % 2 == 0) ? 32'h4 : 32'h0));
                tick(4);
            end
            wr(A_CTL, mb[k]);
            rdchk(A_CNT, ce[k], "edge count");
        end
        finish_test();
    end
endmodule : tpm_bench
